// ===== logic/prt_pkg.sv
// Constants shared by the port read-back and self-test block.
package prt_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] PRT_OFS_RXSEL = 8'h00;
  localparam logic [7:0] PRT_OFS_KEY = 8'h04;
  localparam logic [7:0] PRT_OFS_BITOP = 8'h08;
  localparam logic [7:0] PRT_OFS_WAKEEN = 8'h0c;
  localparam logic [7:0] PRT_OFS_IRQST = 8'h10;
  localparam logic [7:0] PRT_OFS_IRQMSK = 8'h14;
  localparam logic [7:0] PRT_OFS_ADCCH = 8'h18;
  localparam logic [7:0] PRT_OFS_ANSEL = 8'h1c;
  localparam logic [7:0] PRT_OFS_PORT = 8'h20;
  localparam int unsigned PRT_PORT_STRIDE_LSB = 4;
  localparam logic [1:0] PRT_SUB_DATA = 2'h0;
  localparam logic [1:0] PRT_SUB_DIR = 2'h1;
  localparam logic [1:0] PRT_SUB_VIEW = 2'h2;

  // ----------------------------------------------------------------
  // Field layouts and values
  // ----------------------------------------------------------------
  localparam int unsigned PRT_RXSEL_W = 3;
  localparam logic [7:0] PRT_KEY_PATTERN = 8'hca;
  localparam int unsigned PRT_BITOP_BIT_LSB = 0;
  localparam int unsigned PRT_BITOP_SET_POS = 3;
  localparam int unsigned PRT_BITOP_DIR_POS = 4;
  localparam int unsigned PRT_BITOP_PORT_LSB = 5;
  localparam int unsigned PRT_IRQ_W = 2;
  localparam int unsigned PRT_IRQ_WAKE = 0;
  localparam int unsigned PRT_IRQ_RB = 1;

  // ----------------------------------------------------------------
  // Reset values and bus answers
  // ----------------------------------------------------------------
  localparam logic [2:0] PRT_RXSEL_RST = 3'h0;
  localparam logic [7:0] PRT_KEY_RST = 8'h00;
  localparam logic [7:0] PRT_PORT_RST = 8'hff;
  localparam logic [1:0] PRT_RESP_OKAY = 2'h0;
  localparam logic [1:0] PRT_RESP_SLVERR = 2'h2;

endpackage : prt_pkg

// ===== logic/prt_port_readback.sv
// Port read-back self-test, receive pin routing, port registers and wake-up.
//
// How it works
// - Three bits route each receive input pin.
// - Upper five selection bits read as zero.
// - Writing key 0xca enables read-back mode.
// - Key register eight bits, RW, resets zero.
// - Read-back off: pins keep their chosen function.
// - Off: input bits read pin, outputs latch.
// - On: port read returns actual pin levels.
// - Off: analog path only when function selected.
// - On: selected analog channel path forced on.
// - Reset sets data and direction to ones.
// - New outputs drive high unless data written.
// - Bit set/clear reads port, modifies, writes.
// - Port A falling edge wakes from sleep.
//
// Added by the designer: the register addresses and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module prt_port_readback
  import prt_pkg::*;
#(
  parameter int unsigned NPORT = 2,
  parameter int unsigned ADDR_W = 8,
  parameter int unsigned AN_W = 16,
  parameter int unsigned ANCH_W = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NPORT*8-1:0] port_pin_in,
  output logic [NPORT*8-1:0] port_pin_out,
  output logic [NPORT*8-1:0] port_pin_oe_n,
  input wire logic [PRT_RXSEL_W-1:0] rx_first_pin_in,
  input wire logic [PRT_RXSEL_W-1:0] rx_second_pin_in,
  output logic [PRT_RXSEL_W-1:0] serial_rx_out,
  input wire logic sleep_mode,
  output logic wake_req,
  output logic readback_enable_internal,
  output logic [AN_W-1:0] adc_path_on,
  output logic irq
);

  localparam int unsigned PW = (NPORT > 1) ? $clog2(NPORT) : 1;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] prt_view(input logic rb, input logic [7:0] pin,
                                          input logic [7:0] dir, input logic [7:0] dat);
    if (rb) begin
      return pin;
    end
    return (pin & dir) | (dat & ~dir);
  endfunction : prt_view

  function automatic logic prt_hit(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] off;
    off = a - ADDR_W'(PRT_OFS_PORT);
    return (a >= ADDR_W'(PRT_OFS_PORT)) && (32'(off >> PRT_PORT_STRIDE_LSB) < NPORT);
  endfunction : prt_hit

  function automatic logic [PW-1:0] prt_idx(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] off;
    off = a - ADDR_W'(PRT_OFS_PORT);
    return off[PRT_PORT_STRIDE_LSB +: PW];
  endfunction : prt_idx

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [NPORT*8-1:0] pin_s1_reg;
  logic [NPORT*8-1:0] pin_s2_reg;
  logic [PRT_RXSEL_W-1:0] rxa_s1_reg;
  logic [PRT_RXSEL_W-1:0] rxa_s2_reg;
  logic [PRT_RXSEL_W-1:0] rxb_s1_reg;
  logic [PRT_RXSEL_W-1:0] rxb_s2_reg;

  always_ff @(posedge aclk) begin
    pin_s1_reg <= port_pin_in;
    pin_s2_reg <= pin_s1_reg;
    rxa_s1_reg <= rx_first_pin_in;
    rxa_s2_reg <= rxa_s1_reg;
    rxb_s1_reg <= rx_second_pin_in;
    rxb_s2_reg <= rxb_s1_reg;
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  logic aw_full_reg;
  logic w_full_reg;
  logic [ADDR_W-1:0] waddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic wr_do;
  logic wr_ok;

  assign wr_do = aw_full_reg && w_full_reg && !bvalid_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      waddr_reg <= '0;
    end else if (s_axi_awvalid && !aw_full_reg) begin
      aw_full_reg <= 1'b1;
      waddr_reg <= s_axi_awaddr;
    end else if (wr_do) begin
      aw_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_reg <= 1'b0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
    end else if (s_axi_wvalid && !w_full_reg) begin
      w_full_reg <= 1'b1;
      wdata_reg <= s_axi_wdata;
      wstrb_reg <= s_axi_wstrb;
    end else if (wr_do) begin
      w_full_reg <= 1'b0;
    end
  end

  always_comb begin
    unique case (waddr_reg)
      ADDR_W'(PRT_OFS_RXSEL), ADDR_W'(PRT_OFS_KEY), ADDR_W'(PRT_OFS_BITOP),
      ADDR_W'(PRT_OFS_WAKEEN), ADDR_W'(PRT_OFS_IRQST), ADDR_W'(PRT_OFS_IRQMSK),
      ADDR_W'(PRT_OFS_ADCCH), ADDR_W'(PRT_OFS_ANSEL): wr_ok = 1'b1;
      default: wr_ok = prt_hit(waddr_reg) && (waddr_reg[3:2] != PRT_SUB_VIEW)
                       && (waddr_reg[3:2] <= PRT_SUB_VIEW);
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= PRT_RESP_OKAY;
    end else if (wr_do) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_ok ? PRT_RESP_OKAY : PRT_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  assign s_axi_awready = !aw_full_reg;
  assign s_axi_wready = !w_full_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  logic wr_b0;
  logic wr_b1;
  assign wr_b0 = wr_do && wstrb_reg[0];
  assign wr_b1 = wr_do && wstrb_reg[1];

  // ----------------------------------------------------------------
  // Selection, key and configuration registers
  // ----------------------------------------------------------------
  logic [PRT_RXSEL_W-1:0] rxsel_reg;
  logic [7:0] key_reg;
  logic rb_en_reg;
  logic [7:0] wake_en_reg;
  logic [ANCH_W-1:0] adc_ch_reg;
  logic [AN_W-1:0] ansel_reg;
  logic key_match;

  assign key_match = (wdata_reg[7:0] == PRT_KEY_PATTERN);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rxsel_reg <= PRT_RXSEL_RST;
    end else if (wr_b0 && waddr_reg == ADDR_W'(PRT_OFS_RXSEL)) begin
      rxsel_reg <= wdata_reg[PRT_RXSEL_W-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      key_reg <= PRT_KEY_RST;
      rb_en_reg <= 1'b0;
    end else if (wr_b0 && waddr_reg == ADDR_W'(PRT_OFS_KEY)) begin
      key_reg <= wdata_reg[7:0];
      rb_en_reg <= key_match;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_en_reg <= '0;
      adc_ch_reg <= '0;
      ansel_reg <= '0;
    end else begin
      if (wr_b0 && waddr_reg == ADDR_W'(PRT_OFS_WAKEEN)) begin
        wake_en_reg <= wdata_reg[7:0];
      end
      if (wr_b0 && waddr_reg == ADDR_W'(PRT_OFS_ADCCH)) begin
        adc_ch_reg <= wdata_reg[ANCH_W-1:0];
      end
      if (waddr_reg == ADDR_W'(PRT_OFS_ANSEL)) begin
        for (int b = 0; b < AN_W; b++) begin
          if ((b < 8) ? wr_b0 : wr_b1) begin
            ansel_reg[b] <= wdata_reg[b];
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Port data and direction registers
  // ----------------------------------------------------------------
  logic [7:0] dat_reg [NPORT];
  logic [7:0] dir_reg [NPORT];
  logic [7:0] pin_v [NPORT];
  logic bop_do;
  logic [PW-1:0] bop_port;
  logic [2:0] bop_bit;

  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      pin_v[p] = pin_s2_reg[p*8 +: 8];
    end
  end

  assign bop_do = wr_b0 && waddr_reg == ADDR_W'(PRT_OFS_BITOP);
  assign bop_port = wdata_reg[PRT_BITOP_PORT_LSB +: PW];
  assign bop_bit = wdata_reg[PRT_BITOP_BIT_LSB +: 3];

  // Read, modify, write: the data byte taken back is the port view, so
  // input bits pick up their current pin level into the latch.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int p = 0; p < NPORT; p++) begin
        dat_reg[p] <= PRT_PORT_RST;
        dir_reg[p] <= PRT_PORT_RST;
      end
    end else begin
      for (int p = 0; p < NPORT; p++) begin
        logic [7:0] v;
        v = wdata_reg[PRT_BITOP_DIR_POS] ? dir_reg[p] : prt_view(rb_en_reg, pin_v[p], dir_reg[p], dat_reg[p]);
        v[bop_bit] = wdata_reg[PRT_BITOP_SET_POS];
        if (wr_b0 && prt_hit(waddr_reg) && prt_idx(waddr_reg) == PW'(p)) begin
          if (waddr_reg[3:2] == PRT_SUB_DATA) begin
            dat_reg[p] <= wdata_reg[7:0];
          end
          if (waddr_reg[3:2] == PRT_SUB_DIR) begin
            dir_reg[p] <= wdata_reg[7:0];
          end
        end else if (bop_do && 32'(bop_port) < NPORT && bop_port == PW'(p)) begin
          if (wdata_reg[PRT_BITOP_DIR_POS]) begin
            dir_reg[p] <= v;
          end else begin
            dat_reg[p] <= v;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin drive, receive routing and analog paths
  // ----------------------------------------------------------------
  // The pins carry only the chosen function; read-back never drives them.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_pin_out <= {NPORT{PRT_PORT_RST}};
      port_pin_oe_n <= {NPORT{PRT_PORT_RST}};
    end else begin
      for (int p = 0; p < NPORT; p++) begin
        port_pin_out[p*8 +: 8] <= dat_reg[p];
        port_pin_oe_n[p*8 +: 8] <= dir_reg[p];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_rx_out <= '0;
      adc_path_on <= '0;
      readback_enable_internal <= 1'b0;
    end else begin
      for (int i = 0; i < PRT_RXSEL_W; i++) begin
        serial_rx_out[i] <= rxsel_reg[i] ? rxb_s2_reg[i] : rxa_s2_reg[i];
      end
      for (int c = 0; c < AN_W; c++) begin
        adc_path_on[c] <= (32'(adc_ch_reg) == c) && (ansel_reg[c] || rb_en_reg);
      end
      readback_enable_internal <= rb_en_reg;
    end
  end

  // ----------------------------------------------------------------
  // Wake-up and interrupts
  // ----------------------------------------------------------------
  logic [7:0] pa_prev_reg;
  logic wake_ev;
  logic [PRT_IRQ_W-1:0] irq_ev;
  logic [PRT_IRQ_W-1:0] irq_st_reg;
  logic [PRT_IRQ_W-1:0] irq_msk_reg;
  logic [PRT_IRQ_W-1:0] irq_clr;

  assign wake_ev = sleep_mode && |(pa_prev_reg & ~pin_v[0] & wake_en_reg);
  assign irq_ev[PRT_IRQ_WAKE] = wake_ev;
  assign irq_ev[PRT_IRQ_RB] = wr_b0 && waddr_reg == ADDR_W'(PRT_OFS_KEY) && key_match && !rb_en_reg;
  assign irq_clr = (wr_b0 && waddr_reg == ADDR_W'(PRT_OFS_IRQST)) ? wdata_reg[PRT_IRQ_W-1:0] : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pa_prev_reg <= PRT_PORT_RST;
      wake_req <= 1'b0;
    end else begin
      pa_prev_reg <= pin_v[0];
      if (!sleep_mode) begin
        wake_req <= 1'b0;
      end else if (wake_ev) begin
        wake_req <= 1'b1;
      end
    end
  end

  // A new event outranks a clear written in the same cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_st_reg <= '0;
      irq_msk_reg <= '0;
      irq <= 1'b0;
    end else begin
      irq_st_reg <= (irq_st_reg & ~irq_clr) | irq_ev;
      if (wr_b0 && waddr_reg == ADDR_W'(PRT_OFS_IRQMSK)) begin
        irq_msk_reg <= wdata_reg[PRT_IRQ_W-1:0];
      end
      irq <= |(irq_st_reg & irq_msk_reg);
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  logic rd_ok;
  logic [PW-1:0] rp;

  assign rp = prt_idx(s_axi_araddr);

  always_comb begin
    rd_mux = '0;
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      ADDR_W'(PRT_OFS_RXSEL): rd_mux = 32'(rxsel_reg);
      ADDR_W'(PRT_OFS_KEY): rd_mux = 32'(key_reg);
      ADDR_W'(PRT_OFS_BITOP): rd_mux = '0;
      ADDR_W'(PRT_OFS_WAKEEN): rd_mux = 32'(wake_en_reg);
      ADDR_W'(PRT_OFS_IRQST): rd_mux = 32'(irq_st_reg);
      ADDR_W'(PRT_OFS_IRQMSK): rd_mux = 32'(irq_msk_reg);
      ADDR_W'(PRT_OFS_ADCCH): rd_mux = 32'(adc_ch_reg);
      ADDR_W'(PRT_OFS_ANSEL): rd_mux = 32'(ansel_reg);
      default: begin
        if (prt_hit(s_axi_araddr) && s_axi_araddr[3:2] == PRT_SUB_DATA) begin
          rd_mux = 32'(dat_reg[rp]);
        end else if (prt_hit(s_axi_araddr) && s_axi_araddr[3:2] == PRT_SUB_DIR) begin
          rd_mux = 32'(dir_reg[rp]);
        end else if (prt_hit(s_axi_araddr) && s_axi_araddr[3:2] == PRT_SUB_VIEW) begin
          rd_mux = 32'(prt_view(rb_en_reg, pin_v[rp], dir_reg[rp], dat_reg[rp]));
        end else begin
          rd_ok = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= PRT_RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_ok ? PRT_RESP_OKAY : PRT_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

endmodule : prt_port_readback
`default_nettype wire

// ===== verif/prt_port_readback_chk.sv
// Concurrent checks on the top-level pins of the port read-back block.
`timescale 1ns/10ps
`default_nettype none
module prt_port_readback_chk
  import prt_pkg::*;
#(
  parameter int unsigned NPORT = 2,
  parameter int unsigned ADDR_W = 8,
  parameter int unsigned AN_W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [NPORT*8-1:0] port_pin_out,
  input wire logic [NPORT*8-1:0] port_pin_oe_n,
  input wire logic [PRT_RXSEL_W-1:0] rx_first_pin_in,
  input wire logic [PRT_RXSEL_W-1:0] rx_second_pin_in,
  input wire logic [PRT_RXSEL_W-1:0] serial_rx_out,
  input wire logic sleep_mode,
  input wire logic wake_req,
  input wire logic readback_enable_internal,
  input wire logic [AN_W-1:0] adc_path_on
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence key_wr;
    wr_taken ##0 s_axi_awaddr == PRT_OFS_KEY;
  endsequence

  // Two reset edges are needed, since reset is synchronous and the first edge only loads the pin drivers.
  AST_RST_PINS: assert property (disable iff (1'b0) !aresetn [*2] |-> &port_pin_out && &port_pin_oe_n)
    else $error("pins not released to input during reset");
  AST_KEY_ON: assert property (key_wr ##0 s_axi_wdata[7:0] == PRT_KEY_PATTERN |-> ##[3:4] readback_enable_internal)
    else $error("key write did not enable read-back");
  AST_KEY_OFF: assert property (key_wr ##0 s_axi_wdata[7:0] != PRT_KEY_PATTERN |-> ##[3:4] !readback_enable_internal)
    else $error("non-key write left read-back enabled");
  AST_ADC_ONE: assert property ($onehot0(adc_path_on))
    else $error("more than one analog path on");
  AST_RX_ROUTE: assert property ((rx_first_pin_in == rx_second_pin_in && $stable(rx_first_pin_in)) [*5]
    |-> serial_rx_out == rx_first_pin_in)
    else $error("receive routing does not follow pins");
  AST_WAKE_CLR: assert property (!sleep_mode |=> !wake_req)
    else $error("wake request outside sleep");
  AST_B_LAT: assert property (wr_taken |=> !s_axi_bvalid && !s_axi_awready ##1 s_axi_bvalid)
    else $error("write response timing wrong");
  AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not one cycle after address");
  AST_AR_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while data pending");
endmodule : prt_port_readback_chk
`default_nettype wire

// ===== verif/prt_port_readback_tb.sv
// Self-checking bench for the port read-back block.
`timescale 1ns/10ps
`default_nettype none
module prt_port_readback_tb
  import prt_pkg::*;
;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, sleep_mode;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, wake_req, irq;
  logic readback_enable_internal;
  logic [7:0] s_axi_awaddr, s_axi_araddr, p, d, v;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] port_pin_in, port_pin_out, port_pin_oe_n, adc_path_on;
  logic [2:0] rx_first_pin_in, rx_second_pin_in, serial_rx_out;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int mismatches = 0;
  int tests_run = 0;

  prt_port_readback prt_port_readback_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .port_pin_in, .port_pin_out, .port_pin_oe_n, .rx_first_pin_in, .rx_second_pin_in, .serial_rx_out,
    .sleep_mode, .wake_req, .readback_enable_internal, .adc_path_on, .irq);

  // ----------------------------------------------------------------
  // Bus tasks and result checking
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task automatic hung();
    mismatches++;
    tally_and_finish();
  endtask : hung

  task automatic chk(input string n, input logic [33:0] s, input logic [33:0] e);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc

  // Address and data are offered together and each is dropped once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] dat, input logic [1:0] r);
    int t;
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= dat;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    t = 0;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      t++;
    end while (!s_axi_bvalid && t < 50);
    if (t >= 50) hung();
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    int t;
    rq.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    t = 0;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      t++;
    end while (!s_axi_rvalid && t < 50);
    if (t >= 50) hung();
  endtask : rd

  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) chk("rdata", {s_axi_rresp, s_axi_rdata}, rq.pop_front());
    if (s_axi_bvalid && s_axi_bready) chk("bresp", s_axi_bresp, bq.pop_front());
  end

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, sleep_mode, aresetn} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    port_pin_in = 16'hffff;
    p = $urandom(9);
    rx_first_pin_in = p[2:0];
    rx_second_pin_in = p[2:0];
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    cyc(2);
    chk("drive", {port_pin_out, port_pin_oe_n}, 32'hffffffff);
    rd(PRT_OFS_RXSEL, 34'h0);
    rd(PRT_OFS_KEY, 34'h0);
    rd(PRT_OFS_PORT, 34'hff);
    rd(PRT_OFS_PORT + 8'h4, 34'hff);
    wr(PRT_OFS_RXSEL, 32'hff, PRT_RESP_OKAY);
    rd(PRT_OFS_RXSEL, 34'h7);
    rx_second_pin_in <= ~p[2:0];
    for (int s = 0; s < 8; s++) begin
      wr(PRT_OFS_RXSEL, 32'(s), PRT_RESP_OKAY);
      cyc(4);
      chk("rx", serial_rx_out, p[2:0] ^ 3'(s));
    end
    // Direction first, so the new outputs still carry the reset data.
    wr(PRT_OFS_PORT + 8'h4, 32'h0f, PRT_RESP_OKAY);
    cyc(2);
    chk("drive", {port_pin_out[7:0], port_pin_oe_n[7:0]}, 16'hff0f);
    d = $urandom();
    p = $urandom();
    port_pin_in <= {8'hff, p};
    wr(PRT_OFS_PORT, 32'(d), PRT_RESP_OKAY);
    cyc(3);
    chk("out", port_pin_out[7:0], d);
    v = (p & 8'h0f) | (d & 8'hf0);
    rd(PRT_OFS_PORT + 8'h8, 34'(v));
    wr(PRT_OFS_BITOP, 32'h0e, PRT_RESP_OKAY);
    rd(PRT_OFS_PORT, 34'(v | 8'h40));
    wr(PRT_OFS_BITOP, 32'h11, PRT_RESP_OKAY);
    rd(PRT_OFS_PORT + 8'h4, 34'h0d);
    wr(PRT_OFS_ADCCH, 32'h5, PRT_RESP_OKAY);
    wr(PRT_OFS_KEY, 32'hc5, PRT_RESP_OKAY);
    cyc(3);
    chk("rb", {readback_enable_internal, adc_path_on}, 17'h0);
    wr(PRT_OFS_KEY, 32'(PRT_KEY_PATTERN), PRT_RESP_OKAY);
    cyc(3);
    chk("rb", {readback_enable_internal, adc_path_on}, 17'h10020);
    chk("oe_n", port_pin_oe_n[7:0], 8'h0d);
    rd(PRT_OFS_KEY, 34'hca);
    rd(PRT_OFS_IRQST, 34'h2);
    rd(PRT_OFS_PORT + 8'h8, 34'(p));
    wr(PRT_OFS_KEY, 32'h0, PRT_RESP_OKAY);
    wr(PRT_OFS_ANSEL, 32'h20, PRT_RESP_OKAY);
    cyc(3);
    chk("adc", {readback_enable_internal, adc_path_on}, 17'h00020);
    port_pin_in[0] <= 1'b1;
    wr(PRT_OFS_WAKEEN, 32'h1, PRT_RESP_OKAY);
    wr(PRT_OFS_IRQST, 32'h3, PRT_RESP_OKAY);
    wr(PRT_OFS_IRQMSK, 32'h1, PRT_RESP_OKAY);
    sleep_mode <= 1'b1;
    port_pin_in[0] <= 1'b0;
    cyc(6);
    chk("wake", {wake_req, irq}, 2'b11);
    rd(PRT_OFS_IRQST, 34'h1);
    wr(PRT_OFS_IRQMSK, 32'h0, PRT_RESP_OKAY);
    cyc(2);
    chk("irq", irq, 1'b0);
    wr(PRT_OFS_IRQST, 32'h1, PRT_RESP_OKAY);
    wr(PRT_OFS_IRQMSK, 32'h1, PRT_RESP_OKAY);
    sleep_mode <= 1'b0;
    cyc(2);
    chk("wake", {wake_req, irq}, 2'b00);
    wr(8'h2c, 32'h1, PRT_RESP_SLVERR);
    rd(8'h2c, {PRT_RESP_SLVERR, 32'h0});
    wr(PRT_OFS_PORT + 8'h8, 32'h0, PRT_RESP_SLVERR);
    cyc(2);
    tally_and_finish();
  end
endmodule : prt_port_readback_tb

bind prt_port_readback prt_port_readback_chk #(.NPORT(NPORT), .ADDR_W(ADDR_W), .AN_W(AN_W)) chk_inst (
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .port_pin_out,
  .port_pin_oe_n, .rx_first_pin_in, .rx_second_pin_in, .serial_rx_out, .sleep_mode, .wake_req,
  .readback_enable_internal, .adc_path_on);
`default_nettype wire
